// ---- pssa_params.svh ----
// constants of the packed simd alu slice: offsets, field positions, reset values, indices
`ifndef PSSA_PARAMS_SVH
`define PSSA_PARAMS_SVH

`define PSSA_OFS_OPA      8'h00
`define PSSA_OFS_OPB      8'h04
`define PSSA_OFS_CMD      8'h08
`define PSSA_OFS_RESULT   8'h0C
`define PSSA_OFS_FLAGS    8'h10
`define PSSA_OFS_STATUS   8'h14

`define PSSA_FLAG_LSB     28
`define PSSA_ST_WROTE     0
`define PSSA_ST_FLAGS     1
`define PSSA_ST_SUPPR     2
`define PSSA_ST_BADREG    3
`define PSSA_ST_BADOP     4
`define PSSA_ST_DEST_LSB  8

`define PSSA_RST_WORD     32'h0000_0000
`define PSSA_RST_FLAGS    4'h0
`define PSSA_RST_CMD      16'h0000

`define PSSA_IDX_SP       4'hD
`define PSSA_IDX_PC       4'hF
`define PSSA_ADDR_W_MIN   5

`endif

// ---- pssa_pkg.sv ----
// types shared by the packed simd alu slice
package pssa_pkg;

    typedef enum logic [3:0] {
        HALVING_SIGNED_SUB_HALFWORDS,
        HALVING_SIGNED_SUB_BYTES,
        SIGNED_SUB_HALFWORD_PAIR,
        SIGNED_SUB_BYTE_QUAD,
        SIGNED_ADD_SUB_EXCHANGE,
        SIGNED_SUB_ADD_EXCHANGE,
        UNSIGNED_ADD_HALFWORD_PAIR,
        UNSIGNED_ADD_BYTE_QUAD,
        UNSIGNED_ADD_SUB_EXCHANGE,
        UNSIGNED_SUB_ADD_EXCHANGE,
        AND_BIT_TEST,
        XOR_BIT_TEST
    } pssa_op_e;

    // command word as software writes it, lsb first: op, dest, source, option bits
    typedef struct packed {
        logic       shift_carry;
        logic       shift_carry_ok;
        logic       pred_pass;
        logic       dest_omitted;
        logic [3:0] src_idx;
        logic [3:0] dest_idx;
        logic [3:0] op;
    } pssa_cmd_s;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } pssa_flags_s;

    typedef struct packed {
        logic        we;
        logic [3:0]  addr;
        logic [31:0] data;
    } pssa_rfw_s;

endpackage : pssa_pkg

// ---- pssa_alu.sv ----
// packed simd alu slice with a classic wishbone register port
//
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pssa_params.svh"

// How it works
// - halving halfword subtract: per 16-bit lane, signed difference shifted right one bit.
// - halving byte subtract: per byte lane, signed difference shifted right one bit.
// - halving subtract, signed subtract and unsigned add keep all flags.
// - both exchange families keep every condition flag.
// - signed halfword subtract: two lane differences, not halved.
// - signed byte subtract: four lane differences into matching bytes.
// - signed add-sub exchange: top gets first top plus second bottom.
// - signed add-sub exchange: bottom gets first bottom minus second top.
// - signed sub-add exchange: top gets difference, bottom gets exchanged sum.
// - and-test forms first and second source, sets flags, writes no register.
// - xor-test forms first xor second source, sets flags, writes no register.
// - both tests take negative from bit 31, zero from all-zero value.
// - tests load carry from the shifter carry when given, else keep it.
// - tests keep overflow.
// - after xor-test negative equals xor of the two source sign bits.
// - unsigned halfword add: two lane sums into matching halfwords.
// - unsigned byte add: four lane sums into matching bytes.
// - unsigned add-sub exchange: bottom first bottom minus second top, top sum.
// - unsigned sub-add exchange: bottom exchanged sum, top first top minus second bottom.
// - omitted destination means the result goes back to the first source register.
module pssa_alu
    import pssa_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output var  logic [31:0]       wb_dat_o,
    output var  logic              wb_ack_o,
    output var  pssa_rfw_s         rf_wr_o
);

    generate
        if (ADDR_W < `PSSA_ADDR_W_MIN) begin : g_bad_addr_w
            $error("pssa_alu: ADDR_W too small for the register map");
        end
    endgenerate

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction : merge_lanes

    function automatic logic is_test_op(input logic [3:0] op);
        return (op == AND_BIT_TEST) || (op == XOR_BIT_TEST);
    endfunction : is_test_op

    function automatic logic is_known_op(input logic [3:0] op);
        return op <= XOR_BIT_TEST;
    endfunction : is_known_op

    function automatic logic is_banned_reg(input logic [3:0] idx);
        return (idx == `PSSA_IDX_SP) || (idx == `PSSA_IDX_PC);
    endfunction : is_banned_reg

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    logic        ack_q;
    logic [31:0] dat_q;
    logic [31:0] opa_q;
    logic [31:0] opb_q;
    pssa_cmd_s   cmd_q;
    logic        exec_q;
    logic [31:0] result_q;
    pssa_flags_s flags_q;
    logic [31:0] status_q;
    pssa_rfw_s   rfw_q;
    logic        req;
    logic [7:0]  adr;

    assign req      = wb_cyc_i && wb_stb_i && !ack_q;
    assign adr      = 8'(wb_adr_i);
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign rf_wr_o  = rfw_q;

    // one wait state: a request seen at one edge is acked at the next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    // unmapped offsets read as zero and ignore writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= `PSSA_RST_WORD;
        end else if (req && !wb_we_i) begin
            case ({adr[7:2], 2'b00})
                `PSSA_OFS_OPA:    dat_q <= opa_q;
                `PSSA_OFS_OPB:    dat_q <= opb_q;
                `PSSA_OFS_CMD:    dat_q <= {16'h0000, cmd_q};
                `PSSA_OFS_RESULT: dat_q <= result_q;
                `PSSA_OFS_FLAGS:  dat_q <= {flags_q, 28'h000_0000};
                `PSSA_OFS_STATUS: dat_q <= status_q;
                default:          dat_q <= `PSSA_RST_WORD;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opa_q <= `PSSA_RST_WORD;
            opb_q <= `PSSA_RST_WORD;
        end else if (req && wb_we_i) begin
            if ({adr[7:2], 2'b00} == `PSSA_OFS_OPA) begin
                opa_q <= merge_lanes(opa_q, wb_dat_i, wb_sel_i);
            end
            if ({adr[7:2], 2'b00} == `PSSA_OFS_OPB) begin
                opb_q <= merge_lanes(opb_q, wb_dat_i, wb_sel_i);
            end
        end
    end

    // a command write launches one operation in the following cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_q  <= `PSSA_RST_CMD;
            exec_q <= 1'b0;
        end else begin
            exec_q <= req && wb_we_i && ({adr[7:2], 2'b00} == `PSSA_OFS_CMD);
            if (req && wb_we_i && ({adr[7:2], 2'b00} == `PSSA_OFS_CMD)) begin
                cmd_q <= 16'(merge_lanes({16'h0000, cmd_q}, wb_dat_i, wb_sel_i));
            end
        end
    end

    // ------------------------------------------------------------
    // lane arithmetic
    // ------------------------------------------------------------
    logic [31:0] hsub16_c;
    logic [31:0] hsub8_c;
    logic [31:0] sub16_c;
    logic [31:0] sub8_c;
    logic [31:0] add16_c;
    logic [31:0] add8_c;
    logic [31:0] asx_c;
    logic [31:0] sax_c;

    generate
        for (genvar h = 0; h < 2; h++) begin : g_half
            logic [15:0] a;
            logic [15:0] b;
            logic [16:0] d;
            assign a = opa_q[16*h +: 16];
            assign b = opb_q[16*h +: 16];
            assign d = {a[15], a} - {b[15], b};
            assign hsub16_c[16*h +: 16] = d[16:1];
            assign sub16_c[16*h +: 16]  = a - b;
            assign add16_c[16*h +: 16]  = a + b;
        end
        for (genvar i = 0; i < 4; i++) begin : g_byte
            logic [7:0] a;
            logic [7:0] b;
            logic [8:0] d;
            assign a = opa_q[8*i +: 8];
            assign b = opb_q[8*i +: 8];
            assign d = {a[7], a} - {b[7], b};
            assign hsub8_c[8*i +: 8] = d[8:1];
            assign sub8_c[8*i +: 8]  = a - b;
            assign add8_c[8*i +: 8]  = a + b;
        end
    endgenerate

    // wrapped lane sums and differences carry the same bits signed or unsigned
    assign asx_c[31:16] = opa_q[31:16] + opb_q[15:0];
    assign asx_c[15:0]  = opa_q[15:0] - opb_q[31:16];
    assign sax_c[31:16] = opa_q[31:16] - opb_q[15:0];
    assign sax_c[15:0]  = opa_q[15:0] + opb_q[31:16];

    logic [31:0] res_c;
    always_comb begin
        case (pssa_op_e'(cmd_q.op))
            HALVING_SIGNED_SUB_HALFWORDS: res_c = hsub16_c;
            HALVING_SIGNED_SUB_BYTES:     res_c = hsub8_c;
            SIGNED_SUB_HALFWORD_PAIR:     res_c = sub16_c;
            SIGNED_SUB_BYTE_QUAD:         res_c = sub8_c;
            SIGNED_ADD_SUB_EXCHANGE:      res_c = asx_c;
            SIGNED_SUB_ADD_EXCHANGE:      res_c = sax_c;
            UNSIGNED_ADD_HALFWORD_PAIR:   res_c = add16_c;
            UNSIGNED_ADD_BYTE_QUAD:       res_c = add8_c;
            UNSIGNED_ADD_SUB_EXCHANGE:    res_c = asx_c;
            UNSIGNED_SUB_ADD_EXCHANGE:    res_c = sax_c;
            AND_BIT_TEST:                 res_c = opa_q & opb_q;
            XOR_BIT_TEST:                 res_c = opa_q ^ opb_q;
            default:                      res_c = `PSSA_RST_WORD;
        endcase
    end

    // ------------------------------------------------------------
    // execution and write-back
    // ------------------------------------------------------------
    logic       fire;
    logic [3:0] dest_c;

    assign fire   = exec_q && cmd_q.pred_pass && is_known_op(cmd_q.op);
    assign dest_c = cmd_q.dest_omitted ? cmd_q.src_idx : cmd_q.dest_idx;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rfw_q    <= '0;
            result_q <= `PSSA_RST_WORD;
        end else begin
            rfw_q.we <= fire && !is_test_op(cmd_q.op);
            if (fire) begin
                result_q <= res_c;
            end
            if (fire && !is_test_op(cmd_q.op)) begin
                rfw_q.addr <= dest_c;
                rfw_q.data <= res_c;
            end
        end
    end

    // hardware update wins over a software write in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_q <= `PSSA_RST_FLAGS;
        end else if (fire && is_test_op(cmd_q.op)) begin
            flags_q.n <= res_c[31];
            flags_q.z <= (res_c == 32'h0000_0000);
            if (cmd_q.shift_carry_ok) begin
                flags_q.c <= cmd_q.shift_carry;
            end
        end else if (req && wb_we_i && ({adr[7:2], 2'b00} == `PSSA_OFS_FLAGS)
                     && wb_sel_i[3]) begin
            flags_q <= wb_dat_i[`PSSA_FLAG_LSB +: 4];
        end
    end

    // status shows what the last launched command did; banned names are only reported
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_q <= `PSSA_RST_WORD;
        end else if (exec_q) begin
            status_q <= `PSSA_RST_WORD;
            status_q[`PSSA_ST_WROTE]  <= fire && !is_test_op(cmd_q.op);
            status_q[`PSSA_ST_FLAGS]  <= fire && is_test_op(cmd_q.op);
            status_q[`PSSA_ST_SUPPR]  <= !cmd_q.pred_pass;
            status_q[`PSSA_ST_BADREG] <= is_banned_reg(dest_c)
                                         || is_banned_reg(cmd_q.src_idx);
            status_q[`PSSA_ST_BADOP]  <= !is_known_op(cmd_q.op);
            status_q[`PSSA_ST_DEST_LSB +: 4] <= dest_c;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_go;
        exec_q && cmd_q.pred_pass;
    endsequence

    sequence s_test;
        s_go ##0 is_test_op(cmd_q.op);
    endsequence

    sequence s_write;
        s_go ##0 is_known_op(cmd_q.op) && !is_test_op(cmd_q.op);
    endsequence

    a_ack_one_wait: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not given one cycle after request");

    a_packed_flags_keep: assert property (
        s_go ##0 (cmd_q.op <= UNSIGNED_ADD_BYTE_QUAD) |=> $stable(flags_q))
        else $error("packed op changed flags");

    a_exch_flags_keep: assert property (
        s_go ##0 (cmd_q.op >= SIGNED_ADD_SUB_EXCHANGE)
        ##0 (cmd_q.op <= UNSIGNED_SUB_ADD_EXCHANGE) |=> $stable(flags_q))
        else $error("exchange op changed flags");

    a_test_no_write: assert property (s_test |=> !rf_wr_o.we)
        else $error("bit test wrote a register");

    a_test_nz_flags: assert property (s_go ##0 cmd_q.op == AND_BIT_TEST
        |=> flags_q.n == ($past(opa_q[31]) & $past(opb_q[31]))
        && flags_q.z == (($past(opa_q) & $past(opb_q)) == 32'h0000_0000))
        else $error("and test n or z wrong");

    a_test_carry_keep: assert property (s_test ##0 !cmd_q.shift_carry_ok
        |=> $stable(flags_q.c))
        else $error("bit test changed carry without shifter carry");

    a_test_carry_load: assert property (s_test ##0 cmd_q.shift_carry_ok
        |=> flags_q.c == $past(cmd_q.shift_carry))
        else $error("bit test did not load the shifter carry");

    a_test_v_keep: assert property (s_test |=> $stable(flags_q.v))
        else $error("bit test changed overflow");

    a_xor_sign: assert property (s_go ##0 cmd_q.op == XOR_BIT_TEST
        |=> flags_q.n == ($past(opa_q[31]) ^ $past(opb_q[31]))
        && flags_q.z == ($past(opa_q) == $past(opb_q)))
        else $error("xor test n or z wrong");

    a_pred_suppress: assert property (exec_q && !cmd_q.pred_pass
        |=> !rf_wr_o.we && $stable(flags_q))
        else $error("false predicate still took effect");

    a_dest_alias: assert property (s_write ##0 cmd_q.dest_omitted
        |=> rf_wr_o.we && rf_wr_o.addr == $past(cmd_q.src_idx))
        else $error("omitted destination not aliased to first source");

    a_byte_add_wrap: assert property (
        s_go ##0 cmd_q.op == UNSIGNED_ADD_BYTE_QUAD
        |=> rf_wr_o.data[15:8] == 8'($past(opa_q[15:8]) + $past(opb_q[15:8])))
        else $error("byte lane sum wrong");

    a_hsub_lane: assert property (
        s_go ##0 cmd_q.op == HALVING_SIGNED_SUB_HALFWORDS
        |=> rf_wr_o.data[31:16] == 16'(({$past(opa_q[31]), $past(opa_q[31:16])}
                                       - {$past(opb_q[31]), $past(opb_q[31:16])}) >> 1))
        else $error("halving halfword subtract wrong");

    a_hsub8_lane: assert property (
        s_go ##0 cmd_q.op == HALVING_SIGNED_SUB_BYTES
        |=> rf_wr_o.data[7:0] == 8'(({$past(opa_q[7]), $past(opa_q[7:0])}
                                    - {$past(opb_q[7]), $past(opb_q[7:0])}) >> 1))
        else $error("halving byte subtract wrong");

    a_sub16_lane: assert property (
        s_go ##0 cmd_q.op == SIGNED_SUB_HALFWORD_PAIR
        |=> rf_wr_o.data[15:0] == 16'($past(opa_q[15:0]) - $past(opb_q[15:0])))
        else $error("signed halfword subtract wrong");

    a_sub8_lane: assert property (
        s_go ##0 cmd_q.op == SIGNED_SUB_BYTE_QUAD
        |=> rf_wr_o.data[31:24] == 8'($past(opa_q[31:24]) - $past(opb_q[31:24])))
        else $error("signed byte subtract wrong");

    a_add16_lane: assert property (
        s_go ##0 cmd_q.op == UNSIGNED_ADD_HALFWORD_PAIR
        |=> rf_wr_o.data[31:16] == 16'($past(opa_q[31:16]) + $past(opb_q[31:16])))
        else $error("unsigned halfword add wrong");

    a_asx_lanes: assert property (
        s_go ##0 (cmd_q.op == SIGNED_ADD_SUB_EXCHANGE || cmd_q.op == UNSIGNED_ADD_SUB_EXCHANGE)
        |=> rf_wr_o.data[31:16] == 16'($past(opa_q[31:16]) + $past(opb_q[15:0]))
        && rf_wr_o.data[15:0] == 16'($past(opa_q[15:0]) - $past(opb_q[31:16])))
        else $error("add-sub exchange lanes wrong");

    a_sax_lanes: assert property (
        s_go ##0 (cmd_q.op == SIGNED_SUB_ADD_EXCHANGE || cmd_q.op == UNSIGNED_SUB_ADD_EXCHANGE)
        |=> rf_wr_o.data[31:16] == 16'($past(opa_q[31:16]) - $past(opb_q[15:0]))
        && rf_wr_o.data[15:0] == 16'($past(opa_q[15:0]) + $past(opb_q[31:16])))
        else $error("sub-add exchange lanes wrong");

endmodule : pssa_alu
`default_nettype wire

// ---- pssa_rf_model.sv ----
// register file model standing beyond the write-back port of the alu slice
`timescale 1ns/1ps
`default_nettype none

module pssa_rf_model
    import pssa_pkg::*;
(
    input  wire logic      clk_i,
    input  wire logic      rst_i,
    input  wire pssa_rfw_s rf_wr_i,
    output var  int        wr_count_o
);
    logic [31:0] regs_q [16];

    // -----------------------------------------------------------------
    // write-back capture
    // -----------------------------------------------------------------
    // the bench never names stack pointer or program counter, so no index 13 or 15
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_count_o <= 0;
        end else if (rf_wr_i.we) begin
            regs_q[rf_wr_i.addr] <= rf_wr_i.data;
            wr_count_o           <= wr_count_o + 1;
        end
    end
endmodule : pssa_rf_model

`default_nettype wire

// ---- pssa_alu_tb_top.sv ----
// self-checking testbench of the packed simd alu slice
`timescale 1ns/1ps
`default_nettype none

module pssa_alu_tb_top
    import pssa_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    pssa_rfw_s   rf_wr;
    int          wr_count;
    int          miscompares = 0;
    int          total_checks = 0;
    int          exp_writes = 0;
    logic [31:0] seed = 32'hF2BCD179;
    logic [35:0] q_rf [$];
    logic [31:0] q_rd [$];

    always #10 clk_i = ~clk_i;

    pssa_alu #(.ADDR_W(8)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rf_wr_o(rf_wr)
    );

    pssa_rf_model u_rf (.clk_i(clk_i), .rst_i(rst_i), .rf_wr_i(rf_wr), .wr_count_o(wr_count));

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // reference result; lanes are widened by one sign bit so halving keeps the sign
    function automatic logic [31:0] exp_res(logic [3:0] op, logic [31:0] a, logic [31:0] b);
        logic [16:0] d;
        logic [8:0]  e;
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < 2; i++) begin
            d = {a[16*i+15], a[16*i+:16]} - {b[16*i+15], b[16*i+:16]};
            if (op == 4'h0) r[16*i+:16] = d[16:1];
            if (op == 4'h2) r[16*i+:16] = d[15:0];
            if (op == 4'h6) r[16*i+:16] = a[16*i+:16] + b[16*i+:16];
        end
        for (int i = 0; i < 4; i++) begin
            e = {a[8*i+7], a[8*i+:8]} - {b[8*i+7], b[8*i+:8]};
            if (op == 4'h1) r[8*i+:8] = e[8:1];
            if (op == 4'h3) r[8*i+:8] = e[7:0];
            if (op == 4'h7) r[8*i+:8] = a[8*i+:8] + b[8*i+:8];
        end
        if (op == 4'h4 || op == 4'h8) r = {a[31:16] + b[15:0], a[15:0] - b[31:16]};
        if (op == 4'h5 || op == 4'h9) r = {a[31:16] - b[15:0], a[15:0] + b[31:16]};
        if (op == 4'hA) r = a & b;
        if (op == 4'hB) r = a ^ b;
        return r;
    endfunction : exp_res

    task automatic fail(input string what, input logic [35:0] e, input logic [35:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask : fail

    task automatic chk_rf(input logic [35:0] got);
        if (q_rf.size() == 0) fail("unexpected register write", 36'h0, got);
        else fail("register write", q_rf.pop_front(), got);
    endtask : chk_rf

    task automatic chk_rd(input logic [31:0] got);
        if (q_rd.size() == 0) fail("unexpected read", 36'h0, {4'h0, got});
        else fail("read data", {4'h0, q_rd.pop_front()}, {4'h0, got});
    endtask : chk_rd

    // classic single cycle; the request stands until ack is sampled high at a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q_rd.push_back(e);
        wb(1'b0, a, 32'h0, 4'hF);
    endtask : rd

    // -----------------------------------------------------------------
    // result monitor
    // -----------------------------------------------------------------
    always @(negedge clk_i) begin
        if (rf_wr.we === 1'b1) chk_rf({rf_wr.addr, rf_wr.data});
    end

    // read data is taken at the very edge at which the master samples ack high
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) chk_rd(wb_dat_o);
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report

    initial begin
        repeat (40000) @(posedge clk_i);
        miscompares++;
        final_report();
    end

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        logic [31:0] a, b, r, x;
        logic [3:0]  op, f, fe;
        logic [3:0]  dst, src;
        logic        om, pr, ck, cv;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h10, 32'h0);
        wb(1'b1, 8'h20, 32'hFFFF_FFFF, 4'hF);
        rd(8'h20, 32'h0);
        wb(1'b1, 8'h00, 32'h1234_5678, 4'hF);
        wb(1'b1, 8'h00, 32'hAABB_CCDD, 4'hC);
        rd(8'h00, 32'hAABB_5678);
        for (int n = 0; n < 96; n++) begin
            op = 4'(n % 12);
            a = rnd();
            b = rnd();
            x = rnd();
            f = x[3:0];
            dst = 4'(x[7:4] % 12);
            src = 4'(x[11:8] % 12);
            om = x[12];
            pr = (n % 7 != 6);
            ck = x[13];
            cv = x[14];
            if (n % 24 == 11) b = a;
            r = exp_res(op, a, b);
            wb(1'b1, 8'h10, {f, 28'h0}, 4'h8);
            wb(1'b1, 8'h00, a, 4'hF);
            wb(1'b1, 8'h04, b, 4'hF);
            fe = f;
            if (pr && op < 4'hA) begin
                q_rf.push_back({om ? src : dst, r});
                exp_writes++;
            end
            if (pr && op >= 4'hA) begin
                fe = {r[31], r == 32'h0, ck ? cv : f[1], f[0]};
            end
            wb(1'b1, 8'h08, {16'h0, cv, ck, pr, om, src, dst, op}, 4'hF);
            rd(8'h10, {fe, 28'h0});
            if (pr) rd(8'h0C, r);
            rd(8'h14, {20'h0, om ? src : dst, 5'b00000, !pr,
                       pr && op >= 4'hA, pr && op < 4'hA});
        end
        // an unknown op code must neither write nor touch the flags
        wb(1'b1, 8'h08, 32'h0000_235C, 4'hF);
        rd(8'h10, {fe, 28'h0});
        rd(8'h14, 32'h0000_0510);
        repeat (4) @(posedge clk_i);
        fail("write count", 36'(exp_writes), 36'(wr_count));
        fail("pending notes", 36'h0, 36'(q_rf.size() + q_rd.size()));
        final_report();
    end
endmodule : pssa_alu_tb_top

`default_nettype wire
